// file: inc/asc_pkg.sv
// Shared constants and types of the converter sequencer control block.
package asc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the APB).
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CTRL2 = 8'h08;
	localparam logic [7:0] ADDR_CTRL3 = 8'h0C;
	localparam logic [7:0] ADDR_CTRL4 = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h20;
	localparam logic [7:0] RESULT_MASK = 8'hE3;
	localparam int RESULT_IDX = 2;
	localparam int RESULT_W = 10;
	localparam int RESULT_N = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] RESULT_RST = 10'h000;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int C0_MODE = 0;
	localparam int C0_START = 2;
	localparam int C0_TRIG = 3;
	localparam int C0_CHAN = 4;
	localparam int C1_COUNT = 0;
	localparam int C1_PRIO = 2;
	localparam int C1_TEN = 3;
	localparam int C1_AMP = 4;
	localparam int C1_VREF = 6;
	localparam int C2_SH = 0;
	localparam int C2_GROUP = 1;
	localparam int C2_HWTRIG = 3;
	localparam int C3_DMA = 0;
	localparam int C3_MSS = 1;
	localparam int C3_MSTAT = 2;
	localparam int C4_MGRP = 0;

	// ----------------------------------------------------------------
	// Encodings and timing.
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_ONESHOT = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_SWEEP = 2'h2;
	localparam logic [1:0] MODE_RSWEEP = 2'h3;
	localparam logic [1:0] AMP_EXT0 = 2'h1;
	localparam logic [1:0] AMP_EXT1 = 2'h2;
	localparam logic [4:0] PIN_EXT0 = 5'h10;
	localparam logic [4:0] PIN_EXT1 = 5'h11;
	localparam logic [3:0] LAST_OCTET = 4'h7;
	localparam logic [3:0] LAST_MULTI = 4'hF;
	localparam logic [6:0] CYC_8B = 7'h31;
	localparam logic [6:0] CYC_10B = 7'h3B;
	localparam logic [6:0] CYC_8B_SH = 7'h1C;
	localparam logic [6:0] CYC_10B_SH = 7'h21;

	typedef enum {ONESHOT, REPEAT, SWEEP, RSWEEP0, RSWEEP1, MP_SWEEP, MP_RSWEEP} asc_mode_t;
	typedef enum {ST_IDLE, ST_ARMED, ST_BUSY} asc_state_t;

endpackage

// file: inc/asc_conv_if.sv
// Link between the sequencer and its per-pin conversion timer.
`timescale 1ns/1ns
`default_nettype none
interface asc_conv_if;
	logic start;
	logic abort;
	logic ten_bit;
	logic sample_hold;
	logic done;
	modport seq (output start, output abort, output ten_bit, output sample_hold, input done);
	modport timer (input start, input abort, input ten_bit, input sample_hold, output done);
endinterface
`default_nettype wire

// file: rtl/asc_conv_timer.sv
// Per-pin conversion timer: counts the converter clock cycles of one conversion.
`timescale 1ns/1ns
`default_nettype none
module asc_conv_timer (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	asc_conv_if.timer cv
);
	logic [6:0] cnt_r;
	logic [6:0] len_v;
	logic [6:0] len_r;
	logic [7:0] el_r;
	logic run_r;
	logic done_r;

	// ----------------------------------------------------------------
	// Length of one conversion.
	// ----------------------------------------------------------------
	// Sample and hold shortens the conversion at either resolution.
	always_comb begin
		if (cv.sample_hold) begin
			len_v = cv.ten_bit ? asc_pkg::CYC_10B_SH : asc_pkg::CYC_8B_SH; // [R23]
		end else begin
			len_v = cv.ten_bit ? asc_pkg::CYC_10B : asc_pkg::CYC_8B; // [R23]
		end
	end

	// A start while running restarts the count, which is how a retrigger lands.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= 7'h00;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (i_ce) begin
			done_r <= 1'b0;
			if (cv.abort) begin
				run_r <= 1'b0;
			end else if (cv.start) begin
				run_r <= 1'b1;
				cnt_r <= len_v - 7'h01;
			end else if (run_r) begin
				if (cnt_r == 7'h00) begin
					run_r <= 1'b0;
					done_r <= 1'b1; // [R23]
				end else begin
					cnt_r <= cnt_r - 7'h01;
				end
			end
		end
	end

	assign cv.done = done_r;

	// Elapsed-cycle counter read only by the checks below.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			el_r <= 8'h00;
			len_r <= 7'h00;
		end else if (i_ce) begin
			if (cv.start) begin
				el_r <= 8'h01;
				len_r <= len_v;
			end else if (run_r) begin
				el_r <= el_r + 8'h01;
			end
		end
	end

	a_conv_length: assert property (@(posedge i_mclk) disable iff (i_reset) // [R23]
		$rose(done_r) |-> (el_r == {1'b0, len_r} + 8'h01))
		else $error("Conversion length does not match the selected resolution.");

	a_ten_bit_len: assert property (@(posedge i_mclk) disable iff (i_reset) // [R23]
		(i_ce && cv.start && !cv.abort && cv.ten_bit && !cv.sample_hold) |=> (len_r == asc_pkg::CYC_10B))
		else $error("Ten-bit conversion without sample and hold is not 59 cycles.");

endmodule // asc_conv_timer
`default_nettype wire

// file: rtl/asc_top.sv
// Sequencer control of the successive-approximation converter with its APB register file.
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1 - Mode comes from mode bits, priority bit and multi-port bit.
// R2 - Start by software flag, or after it by pin falling edge or timer event.
// R3 - One-shot converts once, then stops; software trigger clears the flag.
// R4 - One-shot raises its interrupt when the single conversion finishes.
// R5 - Repeat mode converts continuously until software clears the flag.
// R6 - Repeat mode interrupts after each conversion only with DMA mode on.
// R7 - Single sweep converts each pin once, then stops; clears software flag.
// R8 - Single sweep interrupts once at the end, or per conversion with DMA.
// R9 - Results go to the pin's result register, or register zero under DMA.
// R10 - Under DMA only register zero is valid; software must not read others.
// R11 - Software reads each result before the next one overwrites it.
// R12 - With DMA and ten-bit results the DMA moves 16-bit words.
// R13 - One-shot and repeat convert one pin from a group or extended input.
// R14 - Single sweep covers the first two, four, six or eight pins.
// R15 - Sweep pin count applies only to sweep modes, ignored otherwise.
// R16 - Multi-port sweep requires DMA, sweep mode and fixed field settings.
// R17 - Amplifier path 01 or 10 only in one-shot or repeat mode.
// R18 - After connecting the reference, software waits one microsecond before starting.
// R19 - Reference stays connected until a running conversion ends.
// R20 - Software touches control registers only when conversion has stopped.
// R21 - Multi-port status is meaningful only with multi-port sweep selected.
// R22 - Multi-port group is 00 without multi-port sweep, 01 with it.
// R23 - Conversion takes 49, 59, 28 or 33 converter clock cycles.
// R24 - Channel select is honoured only in one-shot and repeat modes.
// R25 - Software picks trigger source before trigger select, then sets start.
module asc_top (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_ext_trigger,
	input wire logic i_timer_underflow,
	input wire logic [9:0] i_conv_data,
	output logic o_conv_start,
	output logic o_conv_busy,
	output logic [4:0] o_pin_sel,
	output logic o_ten_bit,
	output logic o_sample_hold,
	output logic o_vref_on,
	output logic o_conv_irq
);
	asc_conv_if conv ();

	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [31:0] rdata;
	logic mapped;
	logic wr_en;
	logic [1:0] mode_r;
	logic start_r;
	logic trig_r;
	logic [2:0] chan_r;
	logic [1:0] count_r;
	logic prio_r;
	logic ten_r;
	logic [1:0] amp_r;
	logic vref_r;
	logic sh_r;
	logic [1:0] group_r;
	logic hwtrig_r;
	logic dma_r;
	logic mss_r;
	logic [1:0] mgrp_r;
	logic [1:0] mstat;
	logic [asc_pkg::RESULT_W-1:0] result_r [asc_pkg::RESULT_N];
	asc_pkg::asc_state_t state_r;
	asc_pkg::asc_mode_t mode_v;
	logic [3:0] idx_r;
	logic [3:0] last_v;
	logic [4:0] pin_r;
	logic conv_go_r;
	logic busy_r;
	logic vref_on_r;
	logic irq_r;
	logic ext_prev_r;
	logic ext_fall;
	logic hw_event;
	logic go;
	logic retrig;
	logic sw_stop;
	logic sw_start;
	logic seq_last;
	logic single_shot;
	logic done_evt;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic asc_pkg::asc_mode_t decode_mode(logic [1:0] m, logic prio, logic multiport_sweep_select);
		case (m)
			asc_pkg::MODE_ONESHOT: decode_mode = asc_pkg::ONESHOT;
			asc_pkg::MODE_REPEAT: decode_mode = asc_pkg::REPEAT;
			asc_pkg::MODE_SWEEP: decode_mode = multiport_sweep_select ? asc_pkg::MP_SWEEP : asc_pkg::SWEEP;
			asc_pkg::MODE_RSWEEP: begin
				if (multiport_sweep_select) begin
					decode_mode = asc_pkg::MP_RSWEEP;
				end else begin
					decode_mode = prio ? asc_pkg::RSWEEP1 : asc_pkg::RSWEEP0;
				end
			end
			default: decode_mode = asc_pkg::ONESHOT;
		endcase
	endfunction

	// Index of the last pin of a sequence; single-pin modes never look at the count.
	function automatic logic [3:0] last_index(asc_pkg::asc_mode_t m, logic [1:0] cnt);
		case (m)
			asc_pkg::SWEEP, asc_pkg::RSWEEP0: last_index = {1'b0, cnt, 1'b1}; // [R14] [R15]
			asc_pkg::RSWEEP1: last_index = asc_pkg::LAST_OCTET;
			asc_pkg::MP_SWEEP, asc_pkg::MP_RSWEEP: last_index = asc_pkg::LAST_MULTI;
			default: last_index = 4'h0;
		endcase
	endfunction

	// Pin code: top two bits pick the group (or the extended inputs), low three the pin.
	function automatic logic [4:0] pin_code(asc_pkg::asc_mode_t m, logic [3:0] i, logic [1:0] amp,
			logic [1:0] grp, logic [2:0] ch);
		case (m)
			asc_pkg::ONESHOT, asc_pkg::REPEAT: begin
				if (amp == asc_pkg::AMP_EXT0) begin
					pin_code = asc_pkg::PIN_EXT0; // [R13]
				end else if (amp == asc_pkg::AMP_EXT1) begin
					pin_code = asc_pkg::PIN_EXT1; // [R13]
				end else begin
					pin_code = {grp, ch}; // [R13] [R24]
				end
			end
			asc_pkg::MP_SWEEP, asc_pkg::MP_RSWEEP: pin_code = {1'b0, i};
			default: pin_code = {grp, i[2:0]}; // [R14]
		endcase
	endfunction

	// ----------------------------------------------------------------
	// APB slave.
	// ----------------------------------------------------------------
	// The answer comes one cycle into the access phase, so data is always from a flop.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (i_ce) begin
			pready_r <= i_psel & i_penable & ~pready_r;
			if (i_psel & i_penable & ~pready_r) begin
				prdata_r <= i_pwrite ? 32'h00000000 : rdata;
				pslverr_r <= ~mapped;
			end
		end
	end

	assign wr_en = i_ce & i_psel & i_penable & pready_r & i_pwrite;
	assign mstat = mss_r ? pin_r[4:3] : 2'h0; // [R21]

	// Read mux; reserved bits read as zero.
	always_comb begin
		rdata = 32'h00000000;
		mapped = 1'b1;
		case (i_paddr)
			asc_pkg::ADDR_CTRL0: begin
				rdata[asc_pkg::C0_MODE +: 2] = mode_r;
				rdata[asc_pkg::C0_START] = start_r;
				rdata[asc_pkg::C0_TRIG] = trig_r;
				rdata[asc_pkg::C0_CHAN +: 3] = chan_r;
			end
			asc_pkg::ADDR_CTRL1: begin
				rdata[asc_pkg::C1_COUNT +: 2] = count_r;
				rdata[asc_pkg::C1_PRIO] = prio_r;
				rdata[asc_pkg::C1_TEN] = ten_r;
				rdata[asc_pkg::C1_AMP +: 2] = amp_r;
				rdata[asc_pkg::C1_VREF] = vref_r;
			end
			asc_pkg::ADDR_CTRL2: begin
				rdata[asc_pkg::C2_SH] = sh_r;
				rdata[asc_pkg::C2_GROUP +: 2] = group_r;
				rdata[asc_pkg::C2_HWTRIG] = hwtrig_r;
			end
			asc_pkg::ADDR_CTRL3: begin
				rdata[asc_pkg::C3_DMA] = dma_r;
				rdata[asc_pkg::C3_MSS] = mss_r;
				rdata[asc_pkg::C3_MSTAT +: 2] = mstat;
			end
			asc_pkg::ADDR_CTRL4: rdata[asc_pkg::C4_MGRP +: 2] = mgrp_r;
			default: begin
				if ((i_paddr & asc_pkg::RESULT_MASK) == asc_pkg::ADDR_RESULT) begin
					rdata[asc_pkg::RESULT_W-1:0] = result_r[i_paddr[asc_pkg::RESULT_IDX +: 3]];
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Control registers.
	// ----------------------------------------------------------------
	assign sw_start = wr_en & (i_paddr == asc_pkg::ADDR_CTRL0) & i_pwdata[asc_pkg::C0_START];
	assign sw_stop = wr_en & (i_paddr == asc_pkg::ADDR_CTRL0) & ~i_pwdata[asc_pkg::C0_START];

	// The start flag: a software write in the ending cycle wins over the hardware clear.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			mode_r <= asc_pkg::CTRL_RST[1:0];
			start_r <= 1'b0;
			trig_r <= 1'b0;
			chan_r <= asc_pkg::CTRL_RST[2:0];
		end else if (wr_en && i_paddr == asc_pkg::ADDR_CTRL0) begin
			mode_r <= i_pwdata[asc_pkg::C0_MODE +: 2];
			start_r <= i_pwdata[asc_pkg::C0_START];
			trig_r <= i_pwdata[asc_pkg::C0_TRIG];
			chan_r <= i_pwdata[asc_pkg::C0_CHAN +: 3];
		end else if (i_ce && done_evt && seq_last && single_shot && !trig_r && !retrig) begin
			start_r <= 1'b0; // [R3] [R7]
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			{vref_r, amp_r, ten_r, prio_r, count_r} <= asc_pkg::CTRL_RST[6:0];
		end else if (wr_en && i_paddr == asc_pkg::ADDR_CTRL1) begin
			count_r <= i_pwdata[asc_pkg::C1_COUNT +: 2];
			prio_r <= i_pwdata[asc_pkg::C1_PRIO];
			ten_r <= i_pwdata[asc_pkg::C1_TEN];
			amp_r <= i_pwdata[asc_pkg::C1_AMP +: 2];
			vref_r <= i_pwdata[asc_pkg::C1_VREF];
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			{hwtrig_r, group_r, sh_r} <= asc_pkg::CTRL_RST[3:0];
			{mss_r, dma_r} <= asc_pkg::CTRL_RST[1:0];
			mgrp_r <= asc_pkg::CTRL_RST[1:0];
		end else if (wr_en) begin
			if (i_paddr == asc_pkg::ADDR_CTRL2) begin
				sh_r <= i_pwdata[asc_pkg::C2_SH];
				group_r <= i_pwdata[asc_pkg::C2_GROUP +: 2];
				hwtrig_r <= i_pwdata[asc_pkg::C2_HWTRIG];
			end
			if (i_paddr == asc_pkg::ADDR_CTRL3) begin
				dma_r <= i_pwdata[asc_pkg::C3_DMA];
				mss_r <= i_pwdata[asc_pkg::C3_MSS];
			end
			if (i_paddr == asc_pkg::ADDR_CTRL4) begin
				mgrp_r <= i_pwdata[asc_pkg::C4_MGRP +: 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Triggers and sequencing.
	// ----------------------------------------------------------------
	assign mode_v = decode_mode(mode_r, prio_r, mss_r); // [R1]
	assign last_v = last_index(mode_v, count_r);
	assign seq_last = idx_r == last_v;
	assign single_shot = (mode_v == asc_pkg::ONESHOT) || (mode_v == asc_pkg::SWEEP) || (mode_v == asc_pkg::MP_SWEEP);
	assign ext_fall = ext_prev_r & ~i_ext_trigger;
	assign hw_event = hwtrig_r ? i_timer_underflow : ext_fall; // [R2]
	assign go = !trig_r || hw_event; // [R2]
	// Retrigger restarts a running sequence, except in the priority sweep.
	assign retrig = trig_r && hw_event && (mode_v != asc_pkg::RSWEEP1);
	assign done_evt = conv.done && (state_r == asc_pkg::ST_BUSY) && !sw_stop;

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			ext_prev_r <= 1'b1;
		end else if (i_ce) begin
			ext_prev_r <= i_ext_trigger;
		end
	end

	// Each finished pin either starts the next one, loops back, or ends the run.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= asc_pkg::ST_IDLE;
			idx_r <= 4'h0;
			pin_r <= 5'h00;
			conv_go_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (i_ce) begin
			conv_go_r <= 1'b0;
			if (sw_stop) begin
				state_r <= asc_pkg::ST_IDLE; // [R3] [R5] [R7]
				busy_r <= 1'b0;
			end else begin
				case (state_r)
					asc_pkg::ST_IDLE: begin
						if (sw_start) begin
							state_r <= asc_pkg::ST_ARMED;
						end
					end
					asc_pkg::ST_ARMED: begin
						if (go) begin
							state_r <= asc_pkg::ST_BUSY; // [R2]
							busy_r <= 1'b1;
							idx_r <= 4'h0;
							pin_r <= pin_code(mode_v, 4'h0, amp_r, group_r, chan_r);
							conv_go_r <= 1'b1;
						end
					end
					asc_pkg::ST_BUSY: begin
						if (retrig || (done_evt && seq_last && !single_shot)) begin
							idx_r <= 4'h0; // [R5]
							pin_r <= pin_code(mode_v, 4'h0, amp_r, group_r, chan_r);
							conv_go_r <= 1'b1;
						end else if (done_evt && !seq_last) begin
							idx_r <= idx_r + 4'h1; // [R7] [R14]
							pin_r <= pin_code(mode_v, idx_r + 4'h1, amp_r, group_r, chan_r);
							conv_go_r <= 1'b1;
						end else if (done_evt) begin
							state_r <= trig_r ? asc_pkg::ST_ARMED : asc_pkg::ST_IDLE; // [R3] [R7]
							busy_r <= 1'b0;
						end
					end
					default: state_r <= asc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	assign conv.start = conv_go_r;
	assign conv.abort = sw_stop;
	assign conv.ten_bit = ten_r;
	assign conv.sample_hold = sh_r;

	asc_conv_timer u_timer (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.cv(conv)
	);

	// ----------------------------------------------------------------
	// Results, interrupt request and reference switch.
	// ----------------------------------------------------------------
	// Under DMA only register zero is written; the others keep stale data.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < asc_pkg::RESULT_N; k++) begin
				result_r[k] <= asc_pkg::RESULT_RST;
			end
		end else if (i_ce && done_evt) begin
			result_r[dma_r ? 3'h0 : pin_r[2:0]] <= i_conv_data; // [R9] [R10]
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			irq_r <= 1'b0;
			vref_on_r <= 1'b0;
		end else if (i_ce) begin
			irq_r <= done_evt && (dma_r || mode_v == asc_pkg::ONESHOT ||
				(mode_v == asc_pkg::SWEEP && seq_last)); // [R4] [R6] [R8]
			// Clearing the reference bit mid-conversion must not cut the reference.
			vref_on_r <= vref_r || (state_r == asc_pkg::ST_BUSY) || conv_go_r; // [R19]
		end
	end

	assign o_pready = pready_r;
	assign o_prdata = prdata_r;
	assign o_pslverr = pslverr_r;
	assign o_conv_start = conv_go_r;
	assign o_conv_busy = busy_r;
	assign o_pin_sel = pin_r;
	assign o_ten_bit = ten_r;
	assign o_sample_hold = sh_r;
	assign o_vref_on = vref_on_r;
	assign o_conv_irq = irq_r;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	a_oneshot_irq: assert property (@(posedge i_mclk) disable iff (i_reset) // [R4]
		(i_ce && done_evt && mode_v == asc_pkg::ONESHOT) |=> o_conv_irq)
		else $error("One-shot conversion finished without an interrupt request.");

	a_repeat_quiet: assert property (@(posedge i_mclk) disable iff (i_reset) // [R6]
		(i_ce && done_evt && mode_v == asc_pkg::REPEAT && !dma_r) |=> !o_conv_irq)
		else $error("Repeat mode raised an interrupt without DMA mode.");

	a_sweep_irq: assert property (@(posedge i_mclk) disable iff (i_reset) // [R8]
		(i_ce && done_evt && mode_v == asc_pkg::SWEEP && !dma_r) |=> (o_conv_irq == $past(seq_last)))
		else $error("Single sweep interrupt not tied to the end of the sequence.");

	a_dma_result: assert property (@(posedge i_mclk) disable iff (i_reset) // [R9]
		(i_ce && done_evt && dma_r) |=> (result_r[0] == $past(i_conv_data)))
		else $error("DMA-mode result not stored in result register zero.");

	a_oneshot_end: assert property (@(posedge i_mclk) disable iff (i_reset) // [R3]
		(i_ce && done_evt && mode_v == asc_pkg::ONESHOT && !trig_r && !sw_start)
		|=> (!start_r && state_r == asc_pkg::ST_IDLE && !o_conv_busy))
		else $error("One-shot software run did not stop and clear its flag.");

	a_sw_stop: assert property (@(posedge i_mclk) disable iff (i_reset) // [R5]
		(i_ce && sw_stop) |=> (state_r == asc_pkg::ST_IDLE && !o_conv_busy && !o_conv_start))
		else $error("Clearing the start flag did not halt conversion.");

	a_trig_wait: assert property (@(posedge i_mclk) disable iff (i_reset) // [R2]
		(i_ce && state_r == asc_pkg::ST_ARMED && trig_r && !hw_event && !sw_stop)
		|=> (state_r == asc_pkg::ST_ARMED && !o_conv_start))
		else $error("Conversion began without the selected hardware trigger.");

	a_repeat_loop: assert property (@(posedge i_mclk) disable iff (i_reset) // [R5]
		(i_ce && done_evt && mode_v == asc_pkg::REPEAT) |=> (o_conv_start && o_conv_busy))
		else $error("Repeat mode paused between conversions.");

	a_vref_hold: assert property (@(posedge i_mclk) disable iff (i_reset) // [R19]
		(i_ce && state_r == asc_pkg::ST_BUSY) |=> o_vref_on)
		else $error("Reference released during a conversion.");

endmodule // asc_top
`default_nettype wire

// file: test/asc_adc_model.sv
// Behavioural converter front end that answers each pin conversion with a traceable code.
`timescale 1ns/1ns
`default_nettype none
module asc_adc_model (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_conv_start,
	input wire logic i_conv_busy,
	input wire logic [4:0] i_pin_sel,
	output logic [9:0] o_conv_data
);
	logic [9:0] val_r;
	// Each start captures the pin and a running count, so a result in the wrong register shows.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			val_r <= 10'h000;
		end else if (i_conv_start) begin
			val_r <= {i_pin_sel, val_r[4:0] + 5'h01};
		end
	end
	// Outside a run the line shows the inverse, so a late sample never passes by luck.
	assign o_conv_data = i_conv_busy ? val_r : ~val_r;
endmodule // asc_adc_model
`default_nettype wire

// file: test/adc_sequencer_control_tb_top.sv
// Self-checking bench of the converter sequencer control block.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_tb_top;
	// ----
	// Signals, design and converter model.
	// ----
	logic clk, rst, psel, pen, pwr, pready, pslverr, ext, ufl, cst, busy, ten, sh, vref, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [31:0] s = 32'h1126;
	logic [9:0] cdata;
	logic [4:0] psl, pin, ep;
	logic [1:0] am;
	int nst, nirq, tst, tirq, cyc, n0, i0, t, d, np, failures, compares;
	int lat[4] = '{49, 59, 28, 33};
	asc_top u_dut (.i_mclk(clk), .i_reset(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_ext_trigger(ext), .i_timer_underflow(ufl), .i_conv_data(cdata), .o_conv_start(cst),
		.o_conv_busy(busy), .o_pin_sel(psl), .o_ten_bit(ten), .o_sample_hold(sh), .o_vref_on(vref),
		.o_conv_irq(irq));
	asc_adc_model u_adc (.i_mclk(clk), .i_reset(rst), .i_conv_start(cst), .i_conv_busy(busy),
		.i_pin_sel(psl), .o_conv_data(cdata));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Counts starts and requests; reading before the edge's updates gives the cycle's own values.
	always @(posedge clk) begin
		if (cst === 1'b1) begin
			nst++;
			tst = cyc;
			pin = psl;
		end
		if (irq === 1'b1) begin
			nirq++;
			tirq = cyc;
		end
		cyc++;
	end
	// ----
	// Shared tasks.
	// ----
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// The request is held until the rising edge at which pready is sampled high, and released at that edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic run(input logic [31:0] c0);
		n0 = nst;
		i0 = nirq;
		apb(1'b1, asc_pkg::ADDR_CTRL0, c0);
		repeat (3) @(negedge clk);
		while (busy !== 1'b0) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// The whole run needs under two thousand cycles; this span leaves a wide margin.
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_of_test();
	end
	// ----
	// Scenarios.
	// ----
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext = 1'b1;
		ufl = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (t = 0; t < 5; t++) begin
			apb(1'b0, 8'(4 * t), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 8'hFC, 32'h0);
		chk(err, 1'b1);
		// One-shot over resolutions, hold modes and the extended inputs, with a random pin count set.
		for (t = 0; t < 4; t++) begin
			r = rnd();
			am = (t == 3) ? 2'h0 : t[1:0];
			apb(1'b1, asc_pkg::ADDR_CTRL1, {26'h0, am, t[0], 1'b0, r[1:0]});
			apb(1'b1, asc_pkg::ADDR_CTRL2, {30'h0, r[2], t[1]});
			run({25'h0, r[6:4], 4'h4});
			ep = (am == 2'h1) ? 5'h10 : (am == 2'h2) ? 5'h11 : {1'b0, r[2], r[6:4]};
			chk(pin, ep);
			chk(nst - n0, 1);
			chk(nirq - i0, 1);
			chk(tirq - tst, lat[t] + 2);
			chk({ten, sh}, {t[0], t[1]});
			apb(1'b0, asc_pkg::ADDR_CTRL0, 32'h0);
			chk(rd[2], 1'b0);
			if (am == 2'h0) begin
				apb(1'b0, asc_pkg::ADDR_RESULT + {r[6:4], 2'b00}, 32'h0);
				chk(rd, {22'h0, pin, nst[4:0]});
			end
		end
		// Single sweep with a random count, without and with DMA mode.
		for (d = 0; d < 2; d++) begin
			r = rnd();
			np = 2 * (int'(r[1:0]) + 1);
			apb(1'b1, asc_pkg::ADDR_CTRL1, {30'h0, r[1:0]});
			apb(1'b1, asc_pkg::ADDR_CTRL3, 32'(d));
			run(32'h6);
			chk(nst - n0, np);
			chk(pin[2:0], np - 1);
			chk(nirq - i0, (d != 0) ? np : 1);
			apb(1'b0, asc_pkg::ADDR_CTRL0, 32'h0);
			chk(rd[2], 1'b0);
			apb(1'b0, asc_pkg::ADDR_RESULT + 8'((d != 0) ? 0 : 4 * (np - 1)), 32'h0);
			chk(rd, {22'h0, pin, nst[4:0]});
		end
		// Repeat mode, then repeat sweep 0 under DMA, each stopped by software in its third conversion.
		for (d = 0; d < 3; d++) begin
			apb(1'b1, asc_pkg::ADDR_CTRL3, 32'(d != 0));
			n0 = nst;
			i0 = nirq;
			apb(1'b1, asc_pkg::ADDR_CTRL0, (d == 2) ? 32'h7 : 32'h5);
			while (nst - n0 < 3) @(negedge clk);
			chk(vref, 1'b1);
			apb(1'b1, asc_pkg::ADDR_CTRL0, 32'h0);
			@(posedge clk);
			@(negedge clk);
			chk(busy, 1'b0);
			chk(vref, 1'b0);
			chk(nirq - i0, (d != 0) ? 2 : 0);
		end
		// Pin edge and timer event starts; source is picked before the trigger bit, then start.
		for (d = 0; d < 2; d++) begin
			apb(1'b1, asc_pkg::ADDR_CTRL2, {28'h0, d[0], 3'h0});
			apb(1'b1, asc_pkg::ADDR_CTRL0, 32'h8);
			run(32'hC);
			chk(nst - n0, 0);
			@(posedge clk);
			if (d != 0) ufl <= 1'b1;
			else ext <= 1'b0;
			@(posedge clk);
			ufl <= 1'b0;
			ext <= 1'b1;
			while (nirq - i0 < 1) @(negedge clk);
			chk(nst - n0, 1);
			apb(1'b1, asc_pkg::ADDR_CTRL0, 32'h0);
		end
		// Multi-port single sweep over both groups; the reference is connected a settling time ahead.
		apb(1'b1, asc_pkg::ADDR_CTRL1, 32'h43);
		apb(1'b1, asc_pkg::ADDR_CTRL2, 32'h3);
		apb(1'b1, asc_pkg::ADDR_CTRL3, 32'h3);
		apb(1'b1, asc_pkg::ADDR_CTRL4, 32'h1);
		repeat (25) @(posedge clk);
		run(32'h6);
		chk(nst - n0, 16);
		chk(nirq - i0, 16);
		chk(pin, 5'h0F);
		apb(1'b0, asc_pkg::ADDR_CTRL3, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, asc_pkg::ADDR_RESULT, 32'h0);
		chk(rd, {22'h0, pin, nst[4:0]});
		end_of_test();
	end
endmodule // adc_sequencer_control_tb_top
`default_nettype wire
